// >>> bench/lane_err_monitor.sv
// Purpose: port-level assertions for the lane error counter control bank
// Assumes: bus, counters and interrupt all on clk; reset async, high
// Notes:   bound into every bank instance from the foot of this file
module lane_err_monitor
    import lane_err_pkg::*;
#(
    parameter int NUM_LINKS = 2
)
(
    input wire logic                            clk,
    input wire logic                            reset,
    input wire logic [lane_err_pkg::ADDR_W-1:0] addr,
    input wire logic [lane_err_pkg::DATA_W-1:0] wdata,
    input wire logic                            wr_en,
    input wire logic                            rd_en,
    input wire logic [NUM_LINKS*3-1:0]          lane0_errors,
    input wire logic [NUM_LINKS*3-1:0]          lane7_errors,
    input wire logic [lane_err_pkg::DATA_W-1:0] rdata,
    input wire logic                            irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // address decode and error activity, named to keep properties short
    wire logic in_counts = (addr >= COUNT_BASE_ADDR)
                        && (addr <= COUNT_BASE_ADDR + 12'h005);
    wire logic mapped = in_counts || (addr == LINK_PAGE_ADDR)
        || (addr == LANE7_CTRL_ADDR) || (addr == LANE0_HOLD_ADDR)
        || (addr == LANE0_CTRL_ADDR) || (addr == LANE7_HOLD_ADDR)
        || (addr == IRQ_STAT_ADDR) || (addr == IRQ_MASK_ADDR);
    wire logic any_err = (|lane0_errors) || (|lane7_errors);
    wire logic mask_wr = wr_en && (addr == IRQ_MASK_ADDR);

    // a write followed at once by a read of the same place
    sequence s_wr_rd(a);
        (wr_en && addr == a) ##1 (rd_en && addr == a);
    endsequence

    property p_rdata_idle;    !rd_en |=> rdata == READ_ZERO; endproperty
    property p_unmapped;  rd_en && !mapped |=> rdata == READ_ZERO; endproperty
    property p_ctrl_rsvd;
        rd_en && addr == LANE7_CTRL_ADDR |=> rdata[7:6] == 2'h0;
    endproperty
    property p_hold_rsvd;
        rd_en && addr == LANE0_HOLD_ADDR |=> rdata[7:3] == 5'h00;
    endproperty
    property p_ctrl_back;
        s_wr_rd(LANE7_CTRL_ADDR) |=> rdata[5:0] == $past(wdata[5:0], 2);
    endproperty
    property p_hold_back;
        s_wr_rd(LANE0_HOLD_ADDR) |=> rdata[2:0] == $past(wdata[2:0], 2);
    endproperty
    property p_page_back;
        s_wr_rd(LINK_PAGE_ADDR) |=> rdata[0] == $past(wdata[0], 2);
    endproperty
    // irq only rises after an error burst or a mask change
    property p_irq_cause;
        $rose(irq) |-> $past(any_err, 2) || $past(any_err, 3)
                    || $past(mask_wr) || $past(mask_wr, 2);
    endproperty
    property p_irq_masked;
        mask_wr && wdata == 8'h00 |=> ##1 !irq;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata not zero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("ctrl rsvd");
    a_hold_rsvd: assert property (p_hold_rsvd)
        else $error("hold rsvd");
    a_ctrl_back: assert property (p_ctrl_back)
        else $error("ctrl value");
    a_hold_back: assert property (p_hold_back)
        else $error("hold value");
    a_page_back: assert property (p_page_back)
        else $error("page value");
    a_irq_cause: assert property (p_irq_cause)
        else $error("stray irq");
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked irq");
endmodule : lane_err_monitor

bind lane_error_counter_control lane_err_monitor #(.NUM_LINKS(NUM_LINKS))
    u_lane_err_monitor (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .lane0_errors(lane0_errors), .lane7_errors(lane7_errors),
    .rdata(rdata), .irq(irq));

// >>> bench/tb.sv
// Purpose: self-checking bench for the lane error counter control bank
// Assumes: 100 MHz clock, async high reset held five cycles
// Notes:   reads are noted in a queue and scored by a separate watcher
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lane_err_pkg::*;

    localparam int NL = 2;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [NL*3-1:0]   lane0_errors = '0;
    logic [NL*3-1:0]   lane7_errors = '0;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic [DATA_W-1:0] exp_q[$];
    logic [ADDR_W-1:0] adr_q[$];
    logic              rd_seen = 1'b0;
    logic [31:0]       lfsr = 32'hA008;
    logic [DATA_W-1:0] cnt_exp [3];
    int                num_errors = 0;
    int                n_compared = 0;

    always #5 clk = ~clk;

    lane_error_counter_control #(.NUM_LINKS(NL)) dut (.clk(clk),
        .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .lane0_errors(lane0_errors),
        .lane7_errors(lane7_errors), .rdata(rdata), .irq(irq));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk(input string      what,
                       input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // strobes stay up until the next call, so operations run back to back
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        adr_q.push_back(a);
    endtask : rd

    // n cycles of error strobes, then one quiet cycle; n = 0 just idles
    task automatic errs(input logic [5:0] l0,
                        input logic [5:0] l7,
                        input int         n);
        repeat (n) begin
            @(posedge clk);
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            lane0_errors <= l0;
            lane7_errors <= l7;
        end
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        lane0_errors <= '0;
        lane7_errors <= '0;
    endtask : errs

    task automatic irq_is(input logic e);
        errs('0, '0, 2);
        @(negedge clk);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask : irq_is

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // read data stand only in the cycle after the strobe: score it there
    always @(posedge clk) rd_seen <= rd_en;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            chk($sformatf("rdata at %h", adr_q.pop_front()),
                exp_q.pop_front(), rdata);
        end
    end

    // a generous bound; the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(LANE7_CTRL_ADDR, 8'h3F);
        rd(LANE0_HOLD_ADDR, 8'h07);
        rd(LINK_PAGE_ADDR, 8'h00);
        wr(12'h123, 8'hFF);
        rd(12'h123, 8'h00);
        wr(LANE0_HOLD_ADDR, 8'hF8);
        rd(LANE0_HOLD_ADDR, 8'h00);
        wr(LANE0_HOLD_ADDR, 8'h07);
        rd(LANE0_HOLD_ADDR, 8'h07);
        errs('0, '0, 0);
        $display("test reset values done");
        // page 1 keeps its own copy; random field values
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(LINK_PAGE_ADDR, 8'h01);
            rd(LINK_PAGE_ADDR, 8'h01);
            wr(LANE7_CTRL_ADDR, lfsr[7:0]);
            rd(LANE7_CTRL_ADDR, lfsr[7:0] & 8'h3F);
            wr(LINK_PAGE_ADDR, 8'h00);
            rd(LANE7_CTRL_ADDR, 8'h3F);
        end
        errs('0, '0, 0);
        $display("test paging done");
        // only the disparity counter enabled, then its reset held
        wr(LANE7_CTRL_ADDR, 8'h08);
        errs('0, 6'h07, 3);
        cnt_exp = '{8'h03, 8'h00, 8'h00};
        for (int t = 0; t < 3; t++) begin
            rd(COUNT_BASE_ADDR + 12'(3 + t), cnt_exp[t]);
        end
        wr(LANE7_CTRL_ADDR, 8'h39);
        errs('0, 6'h07, 2);
        cnt_exp = '{8'h00, 8'h02, 8'h02};
        for (int t = 0; t < 3; t++) begin
            rd(COUNT_BASE_ADDR + 12'(3 + t), cnt_exp[t]);
        end
        errs('0, '0, 0);
        $display("test enables and resets done");
        // lane 0 disparity counter saturates under hold, then wraps
        wr(IRQ_MASK_ADDR, 8'h01);
        wr(LANE0_CTRL_ADDR, 8'h38);
        errs(6'h01, '0, 255);
        rd(COUNT_BASE_ADDR, 8'hFF);
        errs(6'h01, '0, 3);
        rd(COUNT_BASE_ADDR, 8'hFF);
        rd(IRQ_STAT_ADDR, 8'h01);
        irq_is(1'b1);
        wr(IRQ_MASK_ADDR, 8'h00);
        irq_is(1'b0);
        wr(IRQ_MASK_ADDR, 8'h01);
        irq_is(1'b1);
        wr(IRQ_STAT_ADDR, 8'h01);
        irq_is(1'b0);
        rd(IRQ_STAT_ADDR, 8'h00);
        wr(LANE0_HOLD_ADDR, 8'h06);
        errs(6'h01, '0, 2);
        rd(COUNT_BASE_ADDR, 8'h01);
        errs('0, '0, 2);
        $display("test hold and wrap done");
        close_out();
    end
endmodule : tb

// >>> inc/lane_err_pkg.sv
// Purpose: shared constants for the lane error counter control bank
// Assumes: one register clock, 12-bit register address, 8-bit data
// Notes:   counter slot k = lane_slot * 3 + error type
package lane_err_pkg;

    // bus geometry
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 8;

    // field geometry shared by every control register
    localparam int FIELD_W  = 3;
    localparam int ENA_LSB  = 3;
    localparam int RST_LSB  = 0;
    localparam int HOLD_LSB = 0;

    // error types, also the bit order inside every field
    localparam int TYPES             = 3;
    localparam int TYPE_UNEXP_CTRL   = 2;
    localparam int TYPE_INVALID_CODE = 1;
    localparam int TYPE_DISPARITY    = 0;

    // tracked lanes and counter slots
    localparam int LANE_SLOTS = 2;
    localparam int LANE0_SLOT = 0;
    localparam int LANE7_SLOT = 1;
    localparam int COUNTERS   = LANE_SLOTS * TYPES;

    // counters
    localparam int               COUNT_W   = 8;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hFF;

    // register offsets
    localparam logic [ADDR_W-1:0] LINK_PAGE_ADDR  = 12'h300;
    localparam logic [ADDR_W-1:0] LANE7_CTRL_ADDR = 12'h487;
    localparam logic [ADDR_W-1:0] LANE0_HOLD_ADDR = 12'h488;
    localparam logic [ADDR_W-1:0] LANE0_CTRL_ADDR = 12'h4A0;
    localparam logic [ADDR_W-1:0] LANE7_HOLD_ADDR = 12'h4A1;
    localparam logic [ADDR_W-1:0] COUNT_BASE_ADDR = 12'h4B0;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR   = 12'h4C0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 12'h4C1;

    // reset values
    localparam logic [FIELD_W-1:0]  FIELD_RESET = 3'h7;
    localparam logic [COUNTERS-1:0] MASK_RESET  = 6'h00;
    localparam logic [DATA_W-1:0]   READ_ZERO   = 8'h00;

endpackage : lane_err_pkg

// >>> src/error_counter.sv
// Purpose: one eight-bit lane error counter with hold or wrap
// Assumes: error strobe comes from logic on the same clock
// Notes:   clear is a level and wins over counting
module error_counter
    import lane_err_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               clear,
    input  wire logic               enable,
    input  wire logic               hold,
    input  wire logic               error,
    output logic [COUNT_W-1:0]      count,
    output logic                    terminal
);

    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic               at_max;
    logic               bump;
    logic               term_d;
    logic               term_q;

    // a held counter at the top simply ignores further errors
    assign at_max  = (count_q == COUNT_MAX);
    assign bump    = enable && error && !(hold && at_max);
    assign count_d = clear ? '0 :
                     bump  ? count_q + 1'b1 : count_q;
    // pulse only on the step into the top value
    assign term_d  = !clear && bump && (count_d == COUNT_MAX);

    // counter state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            term_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            term_q  <= term_d;
        end
    end

    assign count    = count_q;
    assign terminal = term_q;

endmodule : error_counter

// >>> src/lane_error_counter_control.sv
// Purpose: paged control bank and error counters for lanes 0 and 7
// Assumes: error strobes and bus come from logic on the clk domain
// Notes:   every link page has its own copy of each control field
//
// The implementer's own choice: the plain strobed port.
module lane_error_counter_control
    import lane_err_pkg::*;
#(
    parameter int NUM_LINKS = 2
)
(
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic [lane_err_pkg::ADDR_W-1:0] addr,
    input  wire logic [lane_err_pkg::DATA_W-1:0] wdata,
    input  wire logic                            wr_en,
    input  wire logic                            rd_en,
    input  wire logic [NUM_LINKS*3-1:0]          lane0_errors,
    input  wire logic [NUM_LINKS*3-1:0]          lane7_errors,
    output logic      [lane_err_pkg::DATA_W-1:0] rdata,
    output logic                                 irq
);

    import lane_err_pkg::*;

    // a single link still needs a one-bit page register
    localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    logic              hit_page;
    logic              hit_l7_ctrl;
    logic              hit_l0_hold;
    logic              hit_l0_ctrl;
    logic              hit_l7_hold;
    logic              hit_count;
    logic              hit_stat;
    logic              hit_mask;
    logic [2:0]        count_idx;

    // plain compares keep the decode readable
    assign hit_page    = (addr == LINK_PAGE_ADDR);
    assign hit_l7_ctrl = (addr == LANE7_CTRL_ADDR);
    assign hit_l0_hold = (addr == LANE0_HOLD_ADDR);
    assign hit_l0_ctrl = (addr == LANE0_CTRL_ADDR);
    assign hit_l7_hold = (addr == LANE7_HOLD_ADDR);
    assign hit_stat    = (addr == IRQ_STAT_ADDR);
    assign hit_mask    = (addr == IRQ_MASK_ADDR);

    // counter readback window holds one byte per counter slot
    assign count_idx   = addr[2:0];
    assign hit_count   = (addr[ADDR_W-1:3] == COUNT_BASE_ADDR[ADDR_W-1:3])
                         && (int'(count_idx) < COUNTERS);

    // ------------------------------------------------------------
    // link page selector
    // ------------------------------------------------------------

    logic [PAGE_W-1:0] page_q;
    logic              page_ok;

    // writes of wider page numbers keep only the low bits
    // an out-of-range page turns paged writes off and reads to zero
    assign page_ok = (int'(page_q) < NUM_LINKS);

    // page register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            page_q <= '0;
        end else if (wr_en && hit_page) begin
            page_q <= wdata[PAGE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // per-link control fields and counters
    // ------------------------------------------------------------

    // control fields, indexed by link then lane slot
    logic [FIELD_W-1:0] ena_q  [NUM_LINKS][LANE_SLOTS];
    logic [FIELD_W-1:0] rst_q  [NUM_LINKS][LANE_SLOTS];
    logic [FIELD_W-1:0] hold_q [NUM_LINKS][LANE_SLOTS];

    // counter outputs, indexed by link then counter slot
    logic [COUNT_W-1:0] cnt    [NUM_LINKS][COUNTERS];
    logic [COUNTERS-1:0] term  [NUM_LINKS];

    // write strobes for the currently selected page
    logic               wr_l7_ctrl;
    logic               wr_l0_ctrl;
    logic               wr_l0_hold;
    logic               wr_l7_hold;

    assign wr_l7_ctrl = wr_en && hit_l7_ctrl && page_ok;
    assign wr_l0_ctrl = wr_en && hit_l0_ctrl && page_ok;
    assign wr_l0_hold = wr_en && hit_l0_hold && page_ok;
    assign wr_l7_hold = wr_en && hit_l7_hold && page_ok;

    genvar gl;
    genvar gk;
    generate
        for (gl = 0; gl < NUM_LINKS; gl++) begin : g_link
            logic sel;
            logic [COUNTERS-1:0] err;

            // only the paged copy takes the write
            assign sel = (int'(page_q) == gl);

            // lane errors arrive grouped three per link
            assign err[LANE0_SLOT*TYPES +: TYPES] =
                lane0_errors[gl*TYPES +: TYPES];
            assign err[LANE7_SLOT*TYPES +: TYPES] =
                lane7_errors[gl*TYPES +: TYPES];

            // lane 7 enables and resets share one byte
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    ena_q[gl][LANE7_SLOT] <= FIELD_RESET;
                    rst_q[gl][LANE7_SLOT] <= FIELD_RESET;
                end else if (wr_l7_ctrl && sel) begin
                    ena_q[gl][LANE7_SLOT] <=
                        wdata[ENA_LSB +: FIELD_W];
                    rst_q[gl][LANE7_SLOT] <=
                        wdata[RST_LSB +: FIELD_W];
                end
            end

            // lane 0 enables and resets, same layout as lane 7
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    ena_q[gl][LANE0_SLOT] <= FIELD_RESET;
                    rst_q[gl][LANE0_SLOT] <= FIELD_RESET;
                end else if (wr_l0_ctrl && sel) begin
                    ena_q[gl][LANE0_SLOT] <= wdata[ENA_LSB +: FIELD_W];
                    rst_q[gl][LANE0_SLOT] <= wdata[RST_LSB +: FIELD_W];
                end
            end

            // lane 0 terminal count hold selects
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    hold_q[gl][LANE0_SLOT] <= FIELD_RESET;
                end else if (wr_l0_hold && sel) begin
                    hold_q[gl][LANE0_SLOT] <=
                        wdata[HOLD_LSB +: FIELD_W];
                end
            end

            // lane 7 terminal count hold selects
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    hold_q[gl][LANE7_SLOT] <= FIELD_RESET;
                end else if (wr_l7_hold && sel) begin
                    hold_q[gl][LANE7_SLOT] <= wdata[HOLD_LSB +: FIELD_W];
                end
            end

            // limitation: the counter slots are fixed at lanes 0 and 7;
            // other lanes need more slots and a wider readback window
            // one counter per lane slot and error type
            for (gk = 0; gk < COUNTERS; gk++) begin : g_cnt
                // reset bit is a level: counter stays at zero while set
                error_counter u_counter (
                    .clk      (clk),
                    .reset    (reset),
                    .clear    (rst_q[gl][gk/TYPES][gk%TYPES]),
                    .enable   (ena_q[gl][gk/TYPES][gk%TYPES]),
                    .hold     (hold_q[gl][gk/TYPES][gk%TYPES]),
                    .error    (err[gk]),
                    .count    (cnt[gl][gk]),
                    .terminal (term[gl][gk])
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------

    // a counter reaching 0xFF on any link raises its slot's bit
    logic [COUNTERS-1:0] term_any;

    always_comb begin
        term_any = '0;
        for (int l = 0; l < NUM_LINKS; l++) begin
            term_any = term_any | term[l];
        end
    end

    logic [COUNTERS-1:0] stat_q;
    logic [COUNTERS-1:0] stat_d;
    logic [COUNTERS-1:0] stat_clr;
    logic [COUNTERS-1:0] mask_q;
    logic                irq_q;

    // write one to clear; a new event in the same cycle still sets
    assign stat_clr = (wr_en && hit_stat) ? wdata[COUNTERS-1:0] : '0;
    assign stat_d   = (stat_q & ~stat_clr) | term_any;

    // status and mask registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat_q <= '0;
            mask_q <= MASK_RESET;
        end else begin
            stat_q <= stat_d;
            if (wr_en && hit_mask) begin
                mask_q <= wdata[COUNTERS-1:0];
            end
        end
    end

    // trade-off: registering irq from stat_d costs no cycle on status and one on mask writes, but keeps
    // the output glitch free where it leaves the block
    // registered level interrupt, set on the same edge as the status bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & mask_q);
        end
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // fields of the selected page, zero when the page is unused
    logic [FIELD_W-1:0] sel_ena7;
    logic [FIELD_W-1:0] sel_rst7;
    logic [FIELD_W-1:0] sel_ena0;
    logic [FIELD_W-1:0] sel_rst0;
    logic [FIELD_W-1:0] sel_hold0;
    logic [FIELD_W-1:0] sel_hold7;
    logic [COUNT_W-1:0] sel_count;

    // guard on page_ok keeps the index inside the arrays
    logic [PAGE_W-1:0]  rd_page;
    assign rd_page   = page_ok ? page_q : '0;

    assign sel_ena7  = page_ok ? ena_q[rd_page][LANE7_SLOT]  : '0;
    assign sel_rst7  = page_ok ? rst_q[rd_page][LANE7_SLOT]  : '0;
    assign sel_ena0  = page_ok ? ena_q[rd_page][LANE0_SLOT]  : '0;
    assign sel_rst0  = page_ok ? rst_q[rd_page][LANE0_SLOT]  : '0;
    assign sel_hold0 = page_ok ? hold_q[rd_page][LANE0_SLOT] : '0;
    assign sel_hold7 = page_ok ? hold_q[rd_page][LANE7_SLOT] : '0;
    assign sel_count = (page_ok && hit_count) ?
                       cnt[rd_page][count_idx] : '0;

    // hazard: a status read in the cycle a counter tops out returns the
    // old value; the set lands one edge later and the next read sees it
    // reserved upper bits are tied to zero in every read word
    logic [DATA_W-1:0] rd_mux;

    assign rd_mux =
        hit_page    ? {{(DATA_W-PAGE_W){1'b0}}, page_q}               :
        hit_l7_ctrl ? {2'b00, sel_ena7, sel_rst7}                     :
        hit_l0_hold ? {5'b00000, sel_hold0}                           :
        hit_l0_ctrl ? {2'b00, sel_ena0, sel_rst0}                     :
        hit_l7_hold ? {5'b00000, sel_hold7}                           :
        hit_count   ? sel_count                                       :
        hit_stat    ? {{(DATA_W-COUNTERS){1'b0}}, stat_q}             :
        hit_mask    ? {{(DATA_W-COUNTERS){1'b0}}, mask_q}             :
                      READ_ZERO;

    logic [DATA_W-1:0] rdata_q;

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= READ_ZERO;
        end else if (rd_en) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= READ_ZERO;
        end
    end

    assign rdata = rdata_q;

endmodule : lane_error_counter_control
